// file: rtl/irq_arbiter.v
// Two-level fixed-order arbiter for the interrupt handler
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter #(
  parameter N = 15
) (
  // Requests
  input  wire [N-1:0] i_req,
  input  wire [N-1:0] i_high,
  // Result
  output reg          o_valid,
  output reg          o_is_high,
  output reg  [3:0]   o_index
);
  integer k;
  reg found_hi;
  reg found_lo;
  reg [3:0] idx_hi;
  reg [3:0] idx_lo;
  // ----------------------------------------
  // Priority scan
  // ----------------------------------------
  always @* begin
    found_hi = 1'b0;
    found_lo = 1'b0;
    idx_hi   = 4'h0;
    idx_lo   = 4'h0;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (i_req[k] && i_high[k]) begin
        found_hi = 1'b1;
        idx_hi   = k[3:0];
      end
      if (i_req[k] && !i_high[k]) begin
        found_lo = 1'b1;
        idx_lo   = k[3:0];
      end
    end
    o_valid   = found_hi | found_lo;
    o_is_high = found_hi;
    o_index   = found_hi ? idx_hi : idx_lo;
  end
endmodule // irq_arbiter
`default_nettype wire

// file: rtl/irq_consts.vh
// Constants for the two-level interrupt handler
// Behaviour
// - Source event sets pending flag regardless
// - Enabled pending flag requests long vector call
// - Global enable bit 7 gates everything
// - Flags raised while disabled stay pending
// - Each source has its own enable
// - Flag still set after return re-requests
// - Software write of one acts like event
// - Fifteen sources, reset highest precedence
// - Two levels, high preempts low only
// - High first, then lowest index wins
// - Sample every cycle, best response seven
// - One instruction after return before call
// - Worst response nineteen cycles
// - Equal or higher routine holds off request
// - Vectors 0x0003 plus eight per index
// - External and timer0/1 flags auto clear
// - Multi-flag sources request on any flag
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH
`define IRQ_NUM_SRC        15
`define IRQ_GLOBAL_EN_BIT  7
`define IRQ_EN_BASIC_RST   8'h00
`define IRQ_EN_EXT_RST     8'h00
`define IRQ_PRI_BASIC_RST  8'h80
`define IRQ_PRI_EXT_RST    8'h00
`define IRQ_VEC_BASE       16'h0003
`define IRQ_VEC_STEP_SHIFT 3
`define IRQ_RESET_VEC      16'h0000
`define IRQ_AUTOCLR_MASK   15'h000f
`define IRQ_DETECT_CYC     1
`define IRQ_CALL_CYC       5
`endif

// file: rtl/irq_handler.v
// Two-level interrupt handler: enables, priorities, arbitration, vector call
`timescale 1ns/1ps
`default_nettype none
`include "irq_consts.vh"
module irq_handler #(
  parameter N = `IRQ_NUM_SRC
) (
  // Clock, reset, enable
  input  wire         I_CORE_CLK,
  input  wire         I_RST_N,
  input  wire         I_CE,
  // Source events, one per order index
  input  wire [N-1:0] I_SRC_EVENT,
  // Extra flag levels of multi-flag sources
  input  wire [N-1:0] I_SRC_LEVEL,
  // Software pending-flag writes
  input  wire [N-1:0] I_PEND_WR_EN,
  input  wire [N-1:0] I_PEND_WR_VAL,
  // Enable and priority register writes
  input  wire         I_EN_BASIC_WE,
  input  wire         I_EN_EXT_WE,
  input  wire         I_PRI_BASIC_WE,
  input  wire         I_PRI_EXT_WE,
  input  wire [7:0]   I_WDATA,
  // Sequencer status
  input  wire         I_INSTR_DONE,
  input  wire         I_RETURN_DONE,
  input  wire         I_CALL_ACK,
  // Register read-back
  output wire [7:0]   O_EN_BASIC,
  output wire [7:0]   O_EN_EXT,
  output wire [7:0]   O_PRI_BASIC,
  output wire [7:0]   O_PRI_EXT,
  output wire [N-1:0] O_PENDING,
  // Vector request
  output wire         O_CALL_REQ,
  output reg  [15:0]  O_CALL_VECTOR,
  output wire [1:0]   O_IN_SERVICE
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CALL = 2'd1;
  localparam ST_HOLD = 2'd2;

  reg  [7:0]   en_basic_q;
  reg  [7:0]   en_ext_q;
  reg  [6:0]   pri_basic_q;
  reg  [7:0]   pri_ext_q;
  reg  [1:0]   state_q;
  reg  [1:0]   state_d;
  reg          lvl_lo_q;
  reg          lvl_hi_q;
  reg  [3:0]   sel_q;
  reg          sel_hi_q;
  reg  [15:0]  vec_d;
  reg  [N-1:0] auto_clr;
  wire [N-1:0] auto_mask;
  wire [N-1:0] flag;
  wire [N-1:0] any_flag;
  wire [N-1:0] src_en;
  wire [N-1:0] src_high;
  wire [N-1:0] req;
  wire         arb_valid;
  wire         arb_high;
  wire [3:0]   arb_index;
  wire         can_take;
  integer      k;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      en_basic_q  <= `IRQ_EN_BASIC_RST;
      en_ext_q    <= `IRQ_EN_EXT_RST;
      pri_basic_q <= 7'h00;
      pri_ext_q   <= `IRQ_PRI_EXT_RST;
    end else if (I_CE) begin
      if (I_EN_BASIC_WE) begin
        en_basic_q <= I_WDATA;
      end
      if (I_EN_EXT_WE) begin
        en_ext_q <= I_WDATA;
      end
      if (I_PRI_BASIC_WE) begin
        pri_basic_q <= I_WDATA[6:0];
      end
      if (I_PRI_EXT_WE) begin
        pri_ext_q <= I_WDATA;
      end
    end
  end

  assign O_EN_BASIC  = en_basic_q;
  assign O_EN_EXT    = en_ext_q;
  assign O_PRI_BASIC = `IRQ_PRI_BASIC_RST | {1'b0, pri_basic_q};
  assign O_PRI_EXT   = pri_ext_q;

  // ----------------------------------------
  // Pending flags
  // ----------------------------------------
  assign auto_mask = `IRQ_AUTOCLR_MASK;

  always @* begin
    auto_clr = {N{1'b0}};
    if (I_CALL_ACK && (state_q == ST_CALL)) begin
      for (k = 0; k < N; k = k + 1) begin
        if (sel_q == k[3:0]) begin
          auto_clr[k] = auto_mask[k];
        end
      end
    end
  end

  irq_pending #(
    .N (N)
  ) u_pending (
    .i_clk      (I_CORE_CLK),
    .i_rst_n    (I_RST_N),
    .i_ce       (I_CE),
    .i_event    (I_SRC_EVENT),
    .i_wr_en    (I_PEND_WR_EN),
    .i_wr_val   (I_PEND_WR_VAL),
    .i_auto_clr (auto_clr),
    .o_flag     (flag)
  );

  assign O_PENDING = flag;
  assign any_flag  = flag | I_SRC_LEVEL;

  // ----------------------------------------
  // Enable and level gating
  // ----------------------------------------
  assign src_en   = {en_ext_q, en_basic_q[6:0]};
  assign src_high = {pri_ext_q, pri_basic_q};
  assign req      = en_basic_q[`IRQ_GLOBAL_EN_BIT] ? (any_flag & src_en) : {N{1'b0}};

  irq_arbiter #(
    .N (N)
  ) u_arb (
    .i_req     (req),
    .i_high    (src_high),
    .o_valid   (arb_valid),
    .o_is_high (arb_high),
    .o_index   (arb_index)
  );

  // Preemption by in-service levels
  assign can_take = arb_valid && !lvl_hi_q && (arb_high || !lvl_lo_q);

  always @* begin
    vec_d = `IRQ_VEC_BASE + ({12'h000, arb_index} << `IRQ_VEC_STEP_SHIFT);
  end

  // ----------------------------------------
  // Vector sequencing
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (I_RETURN_DONE) begin
          state_d = ST_HOLD;
        end else if (can_take && I_INSTR_DONE) begin
          state_d = ST_CALL;
        end
      end
      ST_HOLD: begin
        if (I_INSTR_DONE && can_take) begin
          state_d = ST_CALL;
        end else if (I_INSTR_DONE) begin
          state_d = ST_IDLE;
        end
      end
      ST_CALL: begin
        if (I_CALL_ACK) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q       <= ST_IDLE;
      sel_q         <= 4'h0;
      sel_hi_q      <= 1'b0;
      O_CALL_VECTOR <= `IRQ_RESET_VEC;
      lvl_lo_q      <= 1'b0;
      lvl_hi_q      <= 1'b0;
    end else if (I_CE) begin
      state_q <= state_d;
      if ((state_q != ST_CALL) && (state_d == ST_CALL)) begin
        sel_q         <= arb_index;
        sel_hi_q      <= arb_high;
        O_CALL_VECTOR <= vec_d;
      end
      if ((state_q == ST_CALL) && I_CALL_ACK) begin
        if (sel_hi_q) begin
          lvl_hi_q <= 1'b1;
        end else begin
          lvl_lo_q <= 1'b1;
        end
      end else if (I_RETURN_DONE) begin
        if (lvl_hi_q) begin
          lvl_hi_q <= 1'b0;
        end else begin
          lvl_lo_q <= 1'b0;
        end
      end
    end
  end

  assign O_CALL_REQ   = (state_q == ST_CALL);
  assign O_IN_SERVICE = {lvl_hi_q, lvl_lo_q};
endmodule // irq_handler
`default_nettype wire

// file: rtl/irq_pending.v
// Pending flag bank with hardware set, software write and auto clear
`timescale 1ns/1ps
`default_nettype none
module irq_pending #(
  parameter N = 15
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire         i_ce,
  // Set and clear sources
  input  wire [N-1:0] i_event,
  input  wire [N-1:0] i_wr_en,
  input  wire [N-1:0] i_wr_val,
  input  wire [N-1:0] i_auto_clr,
  // Flags
  output wire [N-1:0] o_flag
);
  reg [N-1:0] flag_q;
  genvar g;
  // ----------------------------------------
  // Per-source flag
  // ----------------------------------------
  generate
    for (g = 0; g < N; g = g + 1) begin : g_flag
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          flag_q[g] <= 1'b0;
        end else if (i_ce) begin
          if (i_event[g]) begin
            flag_q[g] <= 1'b1;
          end else if (i_wr_en[g]) begin
            flag_q[g] <= i_wr_val[g];
          end else if (i_auto_clr[g]) begin
            flag_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign o_flag = flag_q;
endmodule // irq_pending
`default_nettype wire

// file: verif/irq_handler_asserts.sv
// Port checker of the interrupt handler
`timescale 1ns/1ps
`default_nettype none
module irq_handler_asserts #(
  parameter N = 15
) (
  // Clock and reset
  input wire logic         I_CORE_CLK,
  input wire logic         I_RST_N,
  // Inputs
  input wire logic [N-1:0] I_SRC_EVENT,
  input wire logic         I_INSTR_DONE,
  input wire logic         I_RETURN_DONE,
  input wire logic         I_CALL_ACK,
  // Outputs
  input wire logic [7:0]   O_EN_BASIC,
  input wire logic [N-1:0] O_PENDING,
  input wire logic         O_CALL_REQ,
  input wire logic [15:0]  O_CALL_VECTOR,
  input wire logic [1:0]   O_IN_SERVICE
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // ----
  // Checks
  // ----
  property p_vec; $rose(O_CALL_REQ) |-> O_CALL_VECTOR[2:0] == 3'h3 && O_CALL_VECTOR <= 16'h0073; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_hold; O_CALL_REQ && !I_CALL_ACK |=> O_CALL_REQ; endproperty
  a_hold: assert property (p_hold) else $error("call dropped");
  property p_ack; O_CALL_REQ && I_CALL_ACK |=> !O_CALL_REQ && O_IN_SERVICE != 2'h0; endproperty
  a_ack: assert property (p_ack) else $error("entry not marked");
  property p_gate; !O_EN_BASIC[7] && !O_CALL_REQ |=> !O_CALL_REQ; endproperty
  a_gate: assert property (p_gate) else $error("call while gated");
  property p_ret; I_RETURN_DONE && !I_INSTR_DONE && !O_CALL_REQ |=> !O_CALL_REQ; endproperty
  a_ret: assert property (p_ret) else $error("call right after return");
  property p_high; O_IN_SERVICE[1] && !O_CALL_REQ |=> !O_CALL_REQ; endproperty
  a_high: assert property (p_high) else $error("high routine preempted");
  property p_pend; |I_SRC_EVENT |=> (O_PENDING & $past(I_SRC_EVENT)) == $past(I_SRC_EVENT); endproperty
  a_pend: assert property (p_pend) else $error("flag not set");
  property p_take; $rose(O_CALL_REQ) |-> $past(I_INSTR_DONE); endproperty
  a_take: assert property (p_take) else $error("call mid instruction");
endmodule  // irq_handler_asserts
`default_nettype wire

// file: verif/seq_model.sv
// Sequencer model: instruction, return and call timing
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Requests
  input  wire logic i_call_req,
  input  wire logic i_ret,
  // Status
  output logic      o_instr_done,
  output logic      o_ret_done,
  output logic      o_call_ack
);
  logic [2:0] cnt_q;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q        <= 3'h0;
      o_instr_done <= 1'h0;
      o_ret_done   <= 1'h0;
      o_call_ack   <= 1'h0;
    end else if (i_call_req && !o_call_ack) begin
      cnt_q        <= cnt_q + 3'h1;
      o_call_ack   <= cnt_q == 3'h3;
      o_instr_done <= 1'h0;
      o_ret_done   <= 1'h0;
    end else begin
      cnt_q        <= 3'h0;
      o_call_ack   <= 1'h0;
      o_ret_done   <= i_ret;
      o_instr_done <= !i_ret;
    end
  end
endmodule  // seq_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the interrupt handler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst_n, ret, idn, rdn, ack, creq;
  logic [3:0]  we;
  logic [7:0]  wd, enb, ene, prb, pre;
  logic [14:0] ev, pwe, pwv, pnd, lv;
  logic [15:0] vec;
  logic [1:0]  ins;
  int          bad_count = 0;
  int          samples_checked = 0;
  irq_handler u_irq_handler (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(1'h1), .I_SRC_EVENT(ev), .I_SRC_LEVEL(lv),
    .I_PEND_WR_EN(pwe), .I_PEND_WR_VAL(pwv), .I_EN_BASIC_WE(we[3]), .I_EN_EXT_WE(we[2]),
    .I_PRI_BASIC_WE(we[1]), .I_PRI_EXT_WE(we[0]), .I_WDATA(wd), .I_INSTR_DONE(idn),
    .I_RETURN_DONE(rdn), .I_CALL_ACK(ack), .O_EN_BASIC(enb), .O_EN_EXT(ene), .O_PRI_BASIC(prb),
    .O_PRI_EXT(pre), .O_PENDING(pnd), .O_CALL_REQ(creq), .O_CALL_VECTOR(vec), .O_IN_SERVICE(ins));
  seq_model u_seq_model (.i_clk(clk), .i_rst_n(rst_n), .i_call_req(creq), .i_ret(ret),
    .o_instr_done(idn), .o_ret_done(rdn), .o_call_ack(ack));
  // ----
  // Tasks
  // ----
  task print_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] s, input logic [7:0] d);
    @(negedge clk);
    we = s;
    wd = d;
    @(negedge clk);
    we = 4'h0;
  endtask
  task pw(input logic [14:0] m, input logic [14:0] v);
    @(negedge clk);
    pwe = m;
    pwv = v;
    @(negedge clk);
    pwe = 15'h0000;
  endtask
  task rtn();
    @(negedge clk);
    ret = 1'h1;
    @(negedge clk);
    ret = 1'h0;
  endtask
  task quiet(input int c);
    repeat (c) begin
      @(negedge clk);
      chk(16'(creq), 16'h0000);
    end
  endtask
  task wt(input logic lv);
    int n;
    n = 0;
    while (creq !== lv) begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        bad_count++;
        print_verdict();
      end
    end
  endtask
  task entry(input logic [15:0] v, input logic [1:0] s);
    wt(1'h1);
    chk(vec, v);
    wt(1'h0);
    chk(16'(ins), 16'(s));
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst_n = 1'h0;
    ret = 1'h0;
    we = 4'h0;
    wd = 8'h00;
    ev = 15'h0000;
    lv = 15'h0000;
    pwe = 15'h0000;
    pwv = 15'h0000;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    chk(16'(enb), 16'h0000);
    chk(16'(prb), 16'h0080);
    chk(16'({ene, pre}), 16'h0000);
    @(negedge clk);
    ev = 15'h0100;
    @(negedge clk);
    ev = 15'h0000;
    chk(16'(pnd), 16'h0100);
    wr(4'h4, 8'h02);
    quiet(4);
    wr(4'h8, 8'h80);
    entry(16'h0043, 2'h1);
    chk(16'(pnd), 16'h0100);
    rtn();
    entry(16'h0043, 2'h1);
    pw(15'h0100, 15'h0000);
    rtn();
    quiet(6);
    chk(16'(ins), 16'h0000);
    wr(4'h8, 8'h87);
    wr(4'h2, 8'h02);
    pw(15'h0001, 15'h0001);
    entry(16'h0003, 2'h1);
    chk(16'(pnd), 16'h0000);
    pw(15'h0006, 15'h0006);
    entry(16'h000b, 2'h3);
    chk(16'(pnd), 16'h0004);
    quiet(4);
    rtn();
    quiet(6);
    chk(16'(ins), 16'h0001);
    rtn();
    entry(16'h0013, 2'h1);
    pw(15'h0004, 15'h0000);
    rtn();
    quiet(6);
    chk(16'(ins), 16'h0000);
    @(negedge clk);
    lv = 15'h0002;
    entry(16'h000b, 2'h2);
    @(negedge clk);
    lv = 15'h0000;
    chk(16'(pnd), 16'h0000);
    print_verdict();
  end
endmodule  // testbench
bind irq_handler irq_handler_asserts #(.N(N)) u_irq_handler_asserts (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
  .I_SRC_EVENT(I_SRC_EVENT), .I_INSTR_DONE(I_INSTR_DONE), .I_RETURN_DONE(I_RETURN_DONE), .I_CALL_ACK(I_CALL_ACK),
  .O_EN_BASIC(O_EN_BASIC), .O_PENDING(O_PENDING), .O_CALL_REQ(O_CALL_REQ), .O_CALL_VECTOR(O_CALL_VECTOR),
  .O_IN_SERVICE(O_IN_SERVICE));
`default_nettype wire
